// ---- adcc_top.sv ----
//  Function
// [RL1] Software selects the RC oscillator when the internal clock is below 1 MHz.
// [RL2] Software keeps the RC oscillator off when the internal clock is 1 MHz or more.
// [RL3] Bit 6 set clocks the converter from the RC oscillator, clear from internal clock.
// [RL4] In RC mode completion is signalled only by the completion flag; the code also sets the interrupt status then.
// [RL5] Software treats results as suspect until the RC oscillator has stabilised.
// [RL6] Any status/control write clears the flag and starts a new conversion; the code starts one only when bit 5 is set.
// [RL7] Bit 7 sets at each conversion end, with the result then readable.
// [RL8] Channel write, power bit cleared or result read clears the flag.
// [RL9] Bit 5 powers the converter; early results may be inaccurate.
// [RL10] Reset clears flag, clock select and power; register reads zero.
// [RL11] Unused bits 4 and 3 read zero; bit 2 carries the channel MSB.
// [RL12] Codes 000-011 select analog inputs 0-3 on port C bits 6 to 3.
// [RL13] Codes 100, 101, 110 select high reference, midpoint, ground; 111 reserved.
// [RL14] The port C pin selected as analog input reads as digital zero.
// [RL15] All other port C pins stay usable as digital inputs; code 100 also reads bit 7 as zero.
// [RL16] The read-only result register holds the latest completed conversion.
// [RL17] With the internal clock a conversion takes 32 cycles.
// [RL18] The sequencer resolves bits one at a time, starting from the MSB.
// [RL19] While powered off the sequencer idles and never sets the flag.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_top (
  // Clock, reset and clock enable.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address and data.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog datapath: comparator result, DAC code, input multiplexer.
  input  wire logic        comparator_high,
  output logic [7:0]       dac_code,
  output logic [2:0]       analog_channel,
  output logic             converter_power_on,
  // RC oscillator enable and its free-running output.
  output logic             rc_osc_enable,
  input  wire logic        rc_osc_clock,
  // Port C digital input pins.
  input  wire logic [7:0]  port_c_pins,
  // Interrupt.
  output logic             irq
);

  adcc_pkg::adcc_state_t q;
  adcc_pkg::adcc_state_t n;
  logic       rst_s1;
  logic       rst_ok;
  logic       rc_edge;
  logic       step_en;
  logic [2:0] bit_sel;
  logic [7:0] resolved;
  logic       finish;
  logic       wr_go;
  logic       rd_go;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic       wr_stat;
  logic       rd_result;
  logic [7:0] analog_mask;
  logic [7:0] port_c_view;
  logic [7:0] status_word;

  // Reset is released through two flip-flops so that all state leaves reset on one edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_ok <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_ok <= rst_s1;
    end
  end

  // Port C bit that the selected channel occupies; code 100 masks bit 7, codes 101 to 111 hold no input pin.
  function automatic logic [7:0] pin_of_channel(input logic [2:0] ch);
    logic [7:0] m;
    m = 8'h00;
    unique case (ch)
      3'b000: m = 8'h40;
      3'b001: m = 8'h20;
      3'b010: m = 8'h10;
      3'b011: m = 8'h08;
      3'b100: m = 8'h80;
      3'b101: m = 8'h00;
      3'b110: m = 8'h00;
      3'b111: m = 8'h00;
    endcase
    return m;
  endfunction

  // The RC oscillator is asynchronous, so its edges are seen only after synchronisation.
  assign rc_edge  = q.rc_s2 & ~q.rc_s3;
  assign step_en  = q.rc_sel ? rc_edge : 1'b1; // RL3
  assign bit_sel  = 3'd7 - q.tick[4:2];
  assign resolved = q.comp_s2 ? q.dac : (q.dac & ~(8'h01 << bit_sel)); // RL18
  assign finish   = (q.seq == adcc_pkg::ADCC_CONV) && step_en &&
                    (q.tick == 5'(`ADCC_CONV_STEPS - 1));

  // Bus decode; a write or read takes effect in the cycle its ready is high.
  assign wr_go     = q.awready;
  assign rd_go     = q.arready;
  assign wr_idx    = s_axi_awaddr[7:2];
  assign rd_idx    = s_axi_araddr[7:2];
  assign wr_stat   = wr_go && (wr_idx == `ADCC_IDX_STATUS_CONTROL) && s_axi_wstrb[0];
  assign rd_result = rd_go && (rd_idx == `ADCC_IDX_RESULT);

  // Only the pin masked for the channel code reads zero (bit 7 for code 100); every other pin passes through.
  assign analog_mask = pin_of_channel(q.chan);
  assign port_c_view = q.pc_s2 & ~analog_mask; // RL14 RL15

  // Unused bits are packed as constant zeros.
  assign status_word = {q.done_flag, q.rc_sel, q.power, 2'b00, q.chan}; // RL11

  // Next-state logic for the whole block.
  always_comb begin
    n = q;

    // Pin synchronisers: the first stage feeds only the second.
    n.comp_s1 = comparator_high;
    n.comp_s2 = q.comp_s1;
    n.rc_s1   = rc_osc_clock;
    n.rc_s2   = q.rc_s1;
    n.rc_s3   = q.rc_s2;
    n.pc_s1   = port_c_pins;
    n.pc_s2   = q.pc_s1;

    // Successive approximation: trial bit at step 0, decision at step 3 of each bit.
    if ((q.seq == adcc_pkg::ADCC_CONV) && step_en) begin
      n.tick = q.tick + 5'd1;
      if (q.tick[1:0] == 2'(`ADCC_STEPS_PER_BIT - 1)) begin
        n.dac = resolved; // RL18
        if (bit_sel != 3'd0) begin
          n.dac = resolved | (8'h01 << (bit_sel - 3'd1)); // RL18
        end
      end
      if (finish) begin
        n.seq       = adcc_pkg::ADCC_IDLE;
        n.tick      = 5'd0;
        n.result    = resolved; // RL16
        n.done_flag = 1'b1; // RL7 RL17 RL4
        n.irq_stat  = 1'b1;
      end
    end

    // A result read clears the flag, but a completion in the same cycle wins.
    if (rd_result && !finish) begin
      n.done_flag = 1'b0; // RL8
    end

    // Interrupt status clears on read unless a new completion arrives together.
    if (rd_go && (rd_idx == `ADCC_IDX_IRQ_STATUS) && !finish) begin
      n.irq_stat = 1'b0;
    end

    // Write response handshake.
    if (!q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    if (wr_go) begin
      n.awready = 1'b0;
      n.wready  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `ADCC_RESP_OKAY;
      unique case (wr_idx)
        `ADCC_IDX_STATUS_CONTROL, `ADCC_IDX_RESULT, `ADCC_IDX_IRQ_STATUS,
        `ADCC_IDX_PORT_C: ;
        `ADCC_IDX_IRQ_MASK: begin
          if (s_axi_wstrb[0]) begin
            n.irq_mask = s_axi_wdata[`ADCC_IRQ_BIT_DONE];
          end
        end
        default: n.bresp = `ADCC_RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // A control write clears the flag and aborts the sequencer; it rearms it only with the power bit set.
    if (wr_stat) begin
      n.rc_sel    = s_axi_wdata[`ADCC_BIT_RC_SELECT]; // RL3
      n.power     = s_axi_wdata[`ADCC_BIT_POWER]; // RL9
      n.chan      = s_axi_wdata[`ADCC_CHAN_MSB:`ADCC_CHAN_LSB]; // RL12 RL13
      n.done_flag = 1'b0; // RL6 RL8
      n.tick      = 5'd0;
      n.dac       = 8'h80; // RL18
      n.seq       = s_axi_wdata[`ADCC_BIT_POWER] ? adcc_pkg::ADCC_CONV
                                                  : adcc_pkg::ADCC_IDLE; // RL6 RL19
    end

    // Powered off: nothing runs and the flag stays clear.
    if (!n.power) begin
      n.seq       = adcc_pkg::ADCC_IDLE; // RL19
      n.tick      = 5'd0;
      n.done_flag = 1'b0; // RL8 RL19
    end

    // Read handshake and data.
    if (!q.arready && !q.rvalid && s_axi_arvalid) begin
      n.arready = 1'b1;
    end
    if (rd_go) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = `ADCC_RESP_OKAY;
      n.rdata   = 32'h0000_0000;
      unique case (rd_idx)
        `ADCC_IDX_STATUS_CONTROL: n.rdata[7:0] = status_word; // RL11
        `ADCC_IDX_RESULT:         n.rdata[7:0] = q.result; // RL16
        `ADCC_IDX_IRQ_STATUS:     n.rdata[0]   = q.irq_stat;
        `ADCC_IDX_IRQ_MASK:       n.rdata[0]   = q.irq_mask;
        `ADCC_IDX_PORT_C:         n.rdata[7:0] = port_c_view; // RL14 RL15
        default:                  n.rresp      = `ADCC_RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // Level interrupt, registered so the output is glitch free.
    n.irq = n.irq_stat & n.irq_mask;
  end

  // State register; the clock enable freezes everything while low.
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      q <= '0; // RL10
    end else if (clk_en) begin
      q <= n;
    end
  end

  // Outputs come straight from state flip-flops.
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_arready      = q.arready;
  assign s_axi_rvalid       = q.rvalid;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rdata        = q.rdata;
  assign dac_code           = q.dac;
  assign analog_channel     = q.chan; // RL12 RL13
  assign converter_power_on = q.power; // RL9
  assign rc_osc_enable      = q.rc_sel; // RL3
  assign irq                = q.irq;

  // A control write with power set restarts at the MSB trial with the flag low.
  write_restart_a: assert property ( // RL6
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && wr_stat && s_axi_wdata[`ADCC_BIT_POWER]) |=>
      (q.seq == adcc_pkg::ADCC_CONV) && (q.tick == 5'd0) && !q.done_flag &&
      (q.dac == 8'h80))
    else $error("control write did not restart the conversion");

  // Completion raises the flag and captures the final approximation.
  done_capture_a: assert property ( // RL7
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && finish && !wr_stat && q.power) |=>
      q.done_flag && (q.result == $past(resolved)) && (q.seq == adcc_pkg::ADCC_IDLE))
    else $error("completion did not set the flag with the result");

  // A result read without a coinciding completion leaves the flag clear.
  result_clear_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && rd_result && !finish) |=> !q.done_flag)
    else $error("result read did not clear the flag");

  // In RC mode the sequencer advances only on oscillator edges.
  rc_route_a: assert property ( // RL3
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && q.rc_sel && (q.seq == adcc_pkg::ADCC_CONV) && !rc_edge && !wr_stat) |=>
      $stable(q.tick) && $stable(q.dac))
    else $error("sequencer stepped without an oscillator edge");

  // Internal clock mode advances one step per enabled cycle from the start.
  conv_length_a: assert property ( // RL17
    @(posedge clk_sys) disable iff (!rst_ok)
    (q.seq == adcc_pkg::ADCC_CONV && !q.rc_sel && q.tick == 5'd0) ##0
    (clk_en && !wr_stat) [*8] |=>
      (q.tick == 5'd8))
    else $error("conversion step count is wrong");

  // Powered off means idle with no flag.
  power_idle_a: assert property ( // RL19
    @(posedge clk_sys) disable iff (!rst_ok)
    !q.power |-> (q.seq == adcc_pkg::ADCC_IDLE) && !q.done_flag)
    else $error("sequencer active while powered off");

  // Leaving reset shows an all-zero control register.
  reset_zero_a: assert property ( // RL10
    @(posedge clk_sys)
    (rst_ok && !$past(rst_ok)) |-> (status_word == `ADCC_RST_STATUS_CONTROL))
    else $error("control register not zero after reset");

  // A status read returns zeros in the unused bits; bit 2 is the channel MSB.
  unused_zero_a: assert property ( // RL11
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && rd_go && rd_idx == `ADCC_IDX_STATUS_CONTROL) |=> (q.rdata[4:3] == 2'b00))
    else $error("unused control bits read nonzero");

  // The pin masked for the channel code reads zero and the rest follow the pins.
  pin_zero_a: assert property ( // RL14
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && rd_go && rd_idx == `ADCC_IDX_PORT_C) |=>
      ((q.rdata[7:0] & $past(analog_mask)) == 8'h00) &&
      ((q.rdata[7:0] | $past(analog_mask)) == ($past(q.pc_s2) | $past(analog_mask))))
    else $error("port C view wrong");

  // The result changes only when a conversion completes.
  result_hold_a: assert property ( // RL16
    @(posedge clk_sys) disable iff (!rst_ok)
    !(clk_en && finish) |=> $stable(q.result))
    else $error("result changed without a completion");

  // Writing the power bit clear stops the sequencer and drops the flag.
  power_off_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && wr_stat && !s_axi_wdata[`ADCC_BIT_POWER]) |=>
      !q.done_flag && (q.seq == adcc_pkg::ADCC_IDLE) && !q.power)
    else $error("power-off write left the converter running");

  // Each decision keeps the decided upper bits and opens the next lower trial bit alone.
  sar_trial_a: assert property ( // RL18
    @(posedge clk_sys) disable iff (!rst_ok)
    (clk_en && step_en && (q.seq == adcc_pkg::ADCC_CONV) && (q.tick[1:0] == 2'h3) &&
     !finish && !wr_stat) |=>
      q.dac[$past(bit_sel) - 3'h1] &&
      ((q.dac & ((8'h01 << ($past(bit_sel) - 3'h1)) - 8'h01)) == 8'h00) &&
      ((q.dac >> $past(bit_sel)) == ($past(resolved) >> $past(bit_sel))))
    else $error("approximation trial bit out of order");

endmodule // adcc_top

// ---- adcc_defs.svh ----
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// Register indices; the bus byte address is four times the index.
`define ADCC_IDX_STATUS_CONTROL 6'h1E
`define ADCC_IDX_RESULT         6'h1F
`define ADCC_IDX_IRQ_STATUS     6'h20
`define ADCC_IDX_IRQ_MASK       6'h21
`define ADCC_IDX_PORT_C         6'h22

// Field positions of the status/control register.
`define ADCC_BIT_DONE           7
`define ADCC_BIT_RC_SELECT      6
`define ADCC_BIT_POWER          5
`define ADCC_CHAN_MSB           2
`define ADCC_CHAN_LSB           0

// Field position of the completion event in the interrupt registers.
`define ADCC_IRQ_BIT_DONE       0

// Reset values.
`define ADCC_RST_STATUS_CONTROL 8'h00
`define ADCC_RST_IRQ_MASK       1'b0

// Conversion timing in converter clock steps.
`define ADCC_CONV_STEPS         32
`define ADCC_STEPS_PER_BIT      4

// AXI response codes.
`define ADCC_RESP_OKAY          2'b00
`define ADCC_RESP_SLVERR        2'b10

`endif

// ---- adcc_pkg.sv ----
package adcc_pkg;

  // Sequencer states.
  typedef enum logic [0:0] {
    ADCC_IDLE,
    ADCC_CONV
  } adcc_seq_t;

  // Complete state of the converter control block.
  typedef struct packed {
    adcc_seq_t   seq;
    logic [4:0]  tick;
    logic [7:0]  dac;
    logic [7:0]  result;
    logic        done_flag;
    logic        rc_sel;
    logic        power;
    logic [2:0]  chan;
    logic        irq_stat;
    logic        irq_mask;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        comp_s1;
    logic        comp_s2;
    logic        rc_s1;
    logic        rc_s2;
    logic        rc_s3;
    logic [7:0]  pc_s1;
    logic [7:0]  pc_s2;
  } adcc_state_t;

endpackage

// ---- adcc_analog_model.sv ----
`timescale 1ns/1ps

module adcc_analog_model (
  // Levels of the four external inputs, full scale 8'hFF.
  input  wire logic [3:0][7:0] input_levels,
  // Converter side of the analog datapath.
  input  wire logic [7:0]      dac_code,
  input  wire logic [2:0]      analog_channel,
  input  wire logic            converter_power_on,
  input  wire logic            rc_osc_enable,
  output logic                 comparator_high,
  output logic                 rc_osc_clock
);
  logic [7:0] level;
  logic       wander;

  // Input multiplexer with the external inputs and the reference channels.
  always_comb begin
    case (analog_channel)
      3'h4:    level = 8'hFF;
      3'h5:    level = 8'h80;
      3'h6:    level = 8'h00;
      3'h7:    level = 8'h5A;
      default: level = input_levels[analog_channel[1:0]];
    endcase
  end

  // An unpowered comparator gives no usable answer, so its output wanders.
  assign comparator_high = converter_power_on ? (level >= dac_code) : wander;

  // Oscillator near 1.5 MHz; it stands low while it is switched off.
  initial begin
    rc_osc_clock = 1'b0;
    wander = 1'b0;
    forever begin
      #333.0;
      wander = ~wander;
      rc_osc_clock = rc_osc_enable ? ~rc_osc_clock : 1'b0;
    end
  end
endmodule // adcc_analog_model

// ---- tb_adcc_top.sv ----
`timescale 1ns/1ps
`include "adcc_defs.svh"

module tb_adcc_top;
  localparam logic [7:0] a_sc  = {`ADCC_IDX_STATUS_CONTROL, 2'b00};
  localparam logic [7:0] a_res = {`ADCC_IDX_RESULT, 2'b00};
  localparam logic [7:0] a_ist = {`ADCC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] a_msk = {`ADCC_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] a_pc  = {`ADCC_IDX_PORT_C, 2'b00};
  localparam logic [1:0] ok    = `ADCC_RESP_OKAY;
  localparam logic [1:0] err   = `ADCC_RESP_SLVERR;

  // Bench drive, design outputs and scoreboard state.
  logic            clk_sys = 1'b0;
  logic            reset_n = 1'b0;
  logic [7:0]      awaddr = 8'h00;
  logic            awvalid = 1'b0;
  logic [31:0]     wdata = 32'h0000_0000;
  logic            wvalid = 1'b0;
  logic            bready = 1'b0;
  logic [7:0]      araddr = 8'h00;
  logic            arvalid = 1'b0;
  logic            rready = 1'b0;
  logic            clk_en = 1'b1;
  logic [7:0]      port_c_pins = 8'h00;
  logic [3:0][7:0] levels = '0;
  logic            awready, wready, bvalid, arready, rvalid, irq;
  logic            comparator_high, converter_power_on, rc_osc_enable, rc_osc_clock;
  logic [1:0]      bresp, rresp;
  logic [31:0]     rdata, got;
  logic [7:0]      dac_code;
  logic [2:0]      analog_channel;
  logic [34:0]     rq[$];
  logic [34:0]     re;
  logic [1:0]      bq[$];
  int              miscompares = 0;
  int              cmp_count = 0;
  int              cycles = 0;
  integer          seed = 32'hf04a;

  adcc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comparator_high(comparator_high), .dac_code(dac_code), .analog_channel(analog_channel),
    .converter_power_on(converter_power_on), .rc_osc_enable(rc_osc_enable),
    .rc_osc_clock(rc_osc_clock), .port_c_pins(port_c_pins), .irq(irq));

  adcc_analog_model partner (.input_levels(levels), .dac_code(dac_code),
    .analog_channel(analog_channel), .converter_power_on(converter_power_on),
    .rc_osc_enable(rc_osc_enable), .comparator_high(comparator_high),
    .rc_osc_clock(rc_osc_clock));

  // Clock at 25 ns period.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic flag(input logic [31:0] g, input logic [31:0] e);
    miscompares++;
    $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) flag({24'h0, g}, {24'h0, e});
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bus write: both channels offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    bq.push_back(er);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_done = aw_done | awready;
      w_done = w_done | wready;
    end
    do @(posedge clk_sys); while (!bvalid);
  endtask

  // Bus read; the expectation is queued for the monitor, care low skips it.
  task automatic rd(input logic [7:0] a, input logic care, input logic [1:0] er,
                    input logic [31:0] ed, output logic [31:0] g);
    rq.push_back({care, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    g = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] ed);
    rd(a, 1'b1, ok, ed, got);
  endtask

  function automatic logic [7:0] lvl(input logic [2:0] ch);
    lvl = (ch == 3'h4) ? 8'hFF : (ch == 3'h5) ? 8'h80 : (ch == 3'h6) ? 8'h00 : levels[ch[1:0]];
  endfunction

  function automatic logic [7:0] pc_view(input logic [7:0] p, input logic [2:0] ch);
    pc_view = p;
    if (ch <= 3'h3) pc_view[3'd6 - ch] = 1'b0;
    else if (ch == 3'h4) pc_view[7] = 1'b0;
  endfunction

  // Monitor: every answer is matched against the oldest queued note.
  always @(posedge clk_sys) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) flag({rresp, rdata[29:0]}, 32'h0);
      else begin
        re = rq.pop_front();
        if (re[34]) cmp_count++;
        if (re[34] && {rresp, rdata} !== re[33:0]) flag(rdata, re[31:0]);
      end
    end
    if (bvalid && bready) begin
      cmp_count++;
      if (bq.size() == 0 || bresp !== bq.pop_front()) flag({30'h0, bresp}, 32'h0);
    end
  end

  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // One internal-clock conversion; waits are placed around the fixed 32 cycles.
  task automatic convert(input logic [2:0] ch);
    logic [31:0] ctl;
    ctl = {24'h0, 5'b00100, ch};
    wr(a_sc, ctl, ok);
    rc(a_sc, ctl);
    chk({5'h0, analog_channel}, {5'h0, ch});
    rc(a_pc, {24'h0, pc_view(port_c_pins, ch)});
    repeat (14) @(posedge clk_sys);
    rc(a_sc, ctl);
    repeat (12) @(posedge clk_sys);
    rc(a_sc, ctl | 32'h0000_0080);
  endtask

  // Main sequence.
  initial begin
    for (int i = 0; i < 4; i++) levels[i] <= 8'($random(seed));
    port_c_pins <= 8'($random(seed));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc(a_sc, 32'h0000_0000);
    rc(a_msk, 32'h0000_0000);
    wr(a_sc, 32'h0000_0098, ok);
    rc(a_sc, 32'h0000_0000);
    wr(a_sc, 32'h0000_00C7, ok);
    rc(a_sc, 32'h0000_0047);
    chk({7'h0, rc_osc_enable}, 8'h01);
    wr(8'h00, 32'h0000_0000, err);
    rd(8'hFC, 1'b1, err, 32'h0000_0000, got);
    wr(a_msk, 32'h0000_0001, ok);
    for (int i = 0; i < 7; i++) begin
      port_c_pins <= 8'($random(seed));
      convert(3'(i));
      chk({7'h0, irq}, 8'h01);
      wr(a_res, {24'h0, ~lvl(3'(i))}, ok);
      rc(a_res, {24'h0, lvl(3'(i))});
      rc(a_sc, {24'h0, 5'b00100, 3'(i)});
      rc(a_ist, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h00);
    end
    wr(a_msk, 32'h0000_0000, ok);
    convert(3'h1);
    chk({7'h0, irq}, 8'h00);
    rc(a_ist, 32'h0000_0001);
    wr(a_sc, 32'h0000_0001, ok);
    rc(a_sc, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    rc(a_sc, 32'h0000_0001);
    rc(a_ist, 32'h0000_0000);
    // Clock enable low freezes the sequencer, so completion slips by the frozen cycles.
    wr(a_sc, 32'h0000_0022, ok);
    clk_en <= 1'b0;
    repeat (40) @(posedge clk_sys);
    clk_en <= 1'b1;
    rc(a_sc, 32'h0000_0022);
    repeat (30) @(posedge clk_sys);
    rc(a_sc, 32'h0000_00A2);
    wr(a_sc, 32'h0000_0040, ok);
    repeat (100) @(posedge clk_sys);
    wr(a_sc, 32'h0000_0060, ok);
    repeat (36) @(posedge clk_sys);
    rc(a_sc, 32'h0000_0060);
    got = 32'h0000_0000;
    for (int n = 0; n < 400 && got[7] !== 1'b1; n++) rd(a_sc, 1'b0, ok, 32'h0, got);
    rc(a_sc, 32'h0000_00E0);
    rc(a_res, {24'h0, lvl(3'h0)});
    report_and_stop();
  end
endmodule // tb_adcc_top
